// [common/ucf_pkg.sv]
/*
  Constants for the USB DMA completion flag block: register offsets,
  field positions, reset values, bank indices and bus states.
  Assumes a 32-bit classic Wishbone slave port with byte addresses.
*/
package ucf_pkg;

  localparam int unsigned REG_W = 16;
  localparam int unsigned EP_W = 8;
  localparam int unsigned NUM_BANK = 4;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;

  // Byte addresses of the word registers
  localparam logic [ADR_W-1:0] OFS_OUT_DONE = 8'h00;
  localparam logic [ADR_W-1:0] OFS_IN_DONE = 8'h04;
  localparam logic [ADR_W-1:0] OFS_OUT_RLD = 8'h08;
  localparam logic [ADR_W-1:0] OFS_IN_RLD = 8'h0c;
  localparam logic [ADR_W-1:0] OFS_OUT_IE = 8'h10;
  localparam logic [ADR_W-1:0] OFS_IN_IE = 8'h14;
  localparam logic [ADR_W-1:0] OFS_OUT_CTRL = 8'h18;
  localparam logic [ADR_W-1:0] OFS_IN_CTRL = 8'h1c;
  localparam logic [ADR_W-1:0] OFS_SRC = 8'h20;
  localparam logic [ADR_W-1:0] OFS_ERR = 8'h24;
  localparam logic [ADR_W-1:0] OFS_ERR_IE = 8'h28;

  // Flag banks, indexed {kind, direction}
  localparam logic [1:0] BANK_OUT_DONE = 2'h0;
  localparam logic [1:0] BANK_IN_DONE = 2'h1;
  localparam logic [1:0] BANK_OUT_RLD = 2'h2;
  localparam logic [1:0] BANK_IN_RLD = 2'h3;

  localparam logic [EP_W-1:0] EP_MASK = 8'hfe;
  localparam logic [EP_W-1:0] EP_RST = 8'h00;
  localparam int unsigned CTRL_RLD_LSB = 8;

  localparam int unsigned SRC_W = 6;
  localparam int unsigned SRC_VALID = 5;
  localparam logic [SRC_W-1:0] SRC_NONE = 6'h00;

  localparam int unsigned ERR_W = 2;
  localparam int unsigned ERR_EP0 = 0;
  localparam int unsigned ERR_IDLE = 1;
  localparam logic [ERR_W-1:0] ERR_RST = 2'h0;

  localparam logic [DAT_W-1:0] DAT_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    UCF_ST_IDLE = 2'b01,
    UCF_ST_ACK = 2'b10
  } ucf_bus_st_t;

endpackage

// [rtl/ucf_flag_bank.sv]
/*
  One bank of per-endpoint completion flags, bits 7 to 1.
  Assumes set and clear strobes come from logic on the same clock.
*/
`timescale 1ns/100ps
module ucf_flag_bank
  import ucf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [EP_W-1:0] set_i,
  input wire logic [EP_W-1:0] clr_i,
  output logic [EP_W-1:0] flags_o
);

  logic [EP_W-1:0] flags_q;
  logic [EP_W-1:0] flags_d;

  // Set is applied after clear so a completion in a clearing cycle survives
  always_comb begin
    flags_d = ((flags_q & ~clr_i) | set_i) & EP_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= EP_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_o = flags_q;

endmodule

// [rtl/ucf_dma_flags.sv]
/*
  USB DMA completion flags: done and reload-done flag registers for OUT
  and IN endpoints 1 to 7, go and reload control bits, per-endpoint DMA
  interrupt enables, an interrupt source register that clears the flag
  it names when read, and a classic Wishbone slave.
  Assumes the DMA engine runs on clk_i and pulses dma_done_i for one
  cycle per finished transfer, with direction and endpoint valid then.
*/
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module ucf_dma_flags
  import ucf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [DAT_W-1:0] wb_dat_o,
  input wire logic dma_done_i,
  input wire logic dma_dir_in_i,
  input wire logic [2:0] dma_ep_i,
  output logic [EP_W-1:0] out_go_o,
  output logic [EP_W-1:0] in_go_o,
  output logic [EP_W-1:0] out_reload_o,
  output logic [EP_W-1:0] in_reload_o,
  output logic dma_go_irq_o,
  output logic dma_rld_irq_o,
  output logic irq_o
);

  function automatic logic [EP_W-1:0] ep_onehot(input logic [2:0] ep);
    logic [EP_W-1:0] v;
    v = '0;
    v[ep] = 1'b1;
    return v;
  endfunction

  function automatic logic reg_hit(input logic [ADR_W-1:0] adr,
                                   input logic [ADR_W-1:0] ofs);
    return adr[ADR_W-1:2] == ofs[ADR_W-1:2];
  endfunction

  // Lowest index wins: done before reload, OUT before IN, low endpoint first
  function automatic logic [SRC_W-1:0] first_pending(
      input logic [NUM_BANK*EP_W-1:0] pend);
    logic [SRC_W-1:0] code;
    code = SRC_NONE;
    for (int i = NUM_BANK * EP_W - 1; i >= 0; i--) begin
      if (pend[i]) begin
        code = {1'b1, 5'(i)};
      end
    end
    return code;
  endfunction

  ucf_bus_st_t st_q;
  logic ack_q;
  logic [DAT_W-1:0] dat_q;
  logic [EP_W-1:0] go_q [2];
  logic [EP_W-1:0] rld_q [2];
  logic [EP_W-1:0] ie_q [2];
  logic [ERR_W-1:0] err_q;
  logic [ERR_W-1:0] err_ie_q;
  logic go_irq_q;
  logic rld_irq_q;
  logic irq_q;

  logic req;
  logic wr_lo;
  logic wr_hi;
  logic rd_src;
  logic [EP_W-1:0] ev_hit;
  logic [EP_W-1:0] rld_now;
  logic [EP_W-1:0] ev_go;
  logic [EP_W-1:0] ev_rld;
  logic ev_dir;
  logic [EP_W-1:0] set_v [NUM_BANK];
  logic [EP_W-1:0] clr_v [NUM_BANK];
  logic [EP_W-1:0] flags [NUM_BANK];
  logic [EP_W-1:0] pend [NUM_BANK];
  logic [NUM_BANK*EP_W-1:0] pend_flat;
  logic [SRC_W-1:0] src_code;
  logic [ERR_W-1:0] err_set;
  logic [ERR_W-1:0] err_clr;
  logic [ERR_W-1:0] err_d;
  logic [DAT_W-1:0] rd_mux;

  // Bus slave: one request is taken in IDLE, answered with a one-cycle ack
  assign req = wb_cyc_i && wb_stb_i && (st_q == UCF_ST_IDLE);
  assign wr_lo = req && wb_we_i && wb_sel_i[0];
  assign wr_hi = req && wb_we_i && wb_sel_i[1];
  assign rd_src = req && !wb_we_i && reg_hit(wb_adr_i, OFS_SRC);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= UCF_ST_IDLE;
    end else begin
      case (st_q)
        UCF_ST_IDLE: begin
          if (req) begin
            st_q <= UCF_ST_ACK;
          end
        end
        UCF_ST_ACK: begin
          st_q <= UCF_ST_IDLE;
        end
        default: begin
          st_q <= UCF_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Completion events, endpoint zero is never flagged
  assign ev_dir = dma_dir_in_i;
  assign ev_hit = dma_done_i ? (ep_onehot(dma_ep_i) & EP_MASK) : EP_RST;
  assign rld_now = ev_dir ? rld_q[1] : rld_q[0];
  assign ev_go = ev_hit & ~rld_now;
  assign ev_rld = ev_hit & rld_now;

  // Bank index is {kind, direction}, bit index is the endpoint number
  always_comb begin
    for (int b = 0; b < NUM_BANK; b++) begin
      set_v[b] = EP_RST;
    end
    set_v[{1'b0, ev_dir}] = ev_go;
    set_v[{1'b1, ev_dir}] = ev_rld;
  end

  // Write-one clears, plus the flag named by a source register read
  always_comb begin
    for (int b = 0; b < NUM_BANK; b++) begin
      clr_v[b] = EP_RST;
    end
    if (wr_lo && reg_hit(wb_adr_i, OFS_OUT_DONE)) begin
      clr_v[BANK_OUT_DONE] = wb_dat_i[EP_W-1:0] & EP_MASK;
    end
    if (wr_lo && reg_hit(wb_adr_i, OFS_IN_DONE)) begin
      clr_v[BANK_IN_DONE] = wb_dat_i[EP_W-1:0] & EP_MASK;
    end
    if (wr_lo && reg_hit(wb_adr_i, OFS_OUT_RLD)) begin
      clr_v[BANK_OUT_RLD] = wb_dat_i[EP_W-1:0] & EP_MASK;
    end
    if (wr_lo && reg_hit(wb_adr_i, OFS_IN_RLD)) begin
      clr_v[BANK_IN_RLD] = wb_dat_i[EP_W-1:0] & EP_MASK;
    end
    if (rd_src && src_code[SRC_VALID]) begin
      clr_v[src_code[4:3]] = clr_v[src_code[4:3]] | ep_onehot(src_code[2:0]);
    end
  end

  for (genvar b = 0; b < NUM_BANK; b++) begin : g_bank
    ucf_flag_bank u_bank (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .set_i(set_v[b]),
      .clr_i(clr_v[b]),
      .flags_o(flags[b])
    );
  end

  // One enable per endpoint gates both kinds of request
  always_comb begin
    for (int b = 0; b < NUM_BANK; b++) begin
      pend[b] = flags[b] & ie_q[b % 2];
      pend_flat[b*EP_W +: EP_W] = pend[b];
    end
  end

  assign src_code = first_pending(pend_flat);

  // Go and reload bits: software arms them, completions retire them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go_q[0] <= EP_RST;
      go_q[1] <= EP_RST;
    end else begin
      for (int d = 0; d < 2; d++) begin
        if (wr_lo && reg_hit(wb_adr_i, d == 0 ? OFS_OUT_CTRL : OFS_IN_CTRL)) begin
          go_q[d] <= wb_dat_i[EP_W-1:0] & EP_MASK & ~(ev_dir == d[0] ? ev_go : EP_RST);
        end else if (ev_dir == d[0]) begin
          go_q[d] <= go_q[d] & ~ev_go;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rld_q[0] <= EP_RST;
      rld_q[1] <= EP_RST;
    end else begin
      for (int d = 0; d < 2; d++) begin
        if (wr_hi && reg_hit(wb_adr_i, d == 0 ? OFS_OUT_CTRL : OFS_IN_CTRL)) begin
          rld_q[d] <= wb_dat_i[CTRL_RLD_LSB +: EP_W] & EP_MASK
                      & ~(ev_dir == d[0] ? ev_rld : EP_RST);
        end else if (ev_dir == d[0]) begin
          rld_q[d] <= rld_q[d] & ~ev_rld;
        end
      end
    end
  end

  // DMA interrupt enables, bit 0 stays zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ie_q[0] <= EP_RST;
      ie_q[1] <= EP_RST;
    end else begin
      if (wr_lo && reg_hit(wb_adr_i, OFS_OUT_IE)) begin
        ie_q[0] <= wb_dat_i[EP_W-1:0] & EP_MASK;
      end
      if (wr_lo && reg_hit(wb_adr_i, OFS_IN_IE)) begin
        ie_q[1] <= wb_dat_i[EP_W-1:0] & EP_MASK;
      end
    end
  end

  // Error status: completion on endpoint zero, or on an endpoint not armed
  assign err_set[ERR_EP0] = dma_done_i && (dma_ep_i == 3'h0);
  assign err_set[ERR_IDLE] = |(ev_hit & ~(ev_dir ? (go_q[1] | rld_q[1])
                                                 : (go_q[0] | rld_q[0])));
  assign err_clr = (wr_lo && reg_hit(wb_adr_i, OFS_ERR)) ? wb_dat_i[ERR_W-1:0] : ERR_RST;
  assign err_d = (err_q & ~err_clr) | err_set;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_q <= ERR_RST;
    end else begin
      err_q <= err_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_ie_q <= ERR_RST;
    end else if (wr_lo && reg_hit(wb_adr_i, OFS_ERR_IE)) begin
      err_ie_q <= wb_dat_i[ERR_W-1:0];
    end
  end

  // Interrupt requests lag the flags by one cycle to come from flip-flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go_irq_q <= 1'b0;
      rld_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      go_irq_q <= |(pend[BANK_OUT_DONE] | pend[BANK_IN_DONE]);
      rld_irq_q <= |(pend[BANK_OUT_RLD] | pend[BANK_IN_RLD]);
      irq_q <= (|pend_flat) || (|(err_q & err_ie_q));
    end
  end

  // Read data; unmapped addresses read as zero and ignore writes
  always_comb begin
    rd_mux = DAT_ZERO;
    if (reg_hit(wb_adr_i, OFS_OUT_DONE)) begin
      rd_mux[EP_W-1:0] = flags[BANK_OUT_DONE];
    end else if (reg_hit(wb_adr_i, OFS_IN_DONE)) begin
      rd_mux[EP_W-1:0] = flags[BANK_IN_DONE];
    end else if (reg_hit(wb_adr_i, OFS_OUT_RLD)) begin
      rd_mux[EP_W-1:0] = flags[BANK_OUT_RLD];
    end else if (reg_hit(wb_adr_i, OFS_IN_RLD)) begin
      rd_mux[EP_W-1:0] = flags[BANK_IN_RLD];
    end else if (reg_hit(wb_adr_i, OFS_OUT_IE)) begin
      rd_mux[EP_W-1:0] = ie_q[0];
    end else if (reg_hit(wb_adr_i, OFS_IN_IE)) begin
      rd_mux[EP_W-1:0] = ie_q[1];
    end else if (reg_hit(wb_adr_i, OFS_OUT_CTRL)) begin
      rd_mux[REG_W-1:0] = {rld_q[0], go_q[0]};
    end else if (reg_hit(wb_adr_i, OFS_IN_CTRL)) begin
      rd_mux[REG_W-1:0] = {rld_q[1], go_q[1]};
    end else if (reg_hit(wb_adr_i, OFS_SRC)) begin
      rd_mux[SRC_W-1:0] = src_code;
    end else if (reg_hit(wb_adr_i, OFS_ERR)) begin
      rd_mux[ERR_W-1:0] = err_q;
    end else if (reg_hit(wb_adr_i, OFS_ERR_IE)) begin
      rd_mux[ERR_W-1:0] = err_ie_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= DAT_ZERO;
    end else if (req && !wb_we_i) begin
      dat_q <= rd_mux;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign out_go_o = go_q[0];
  assign in_go_o = go_q[1];
  assign out_reload_o = rld_q[0];
  assign in_reload_o = rld_q[1];
  assign dma_go_irq_o = go_irq_q;
  assign dma_rld_irq_o = rld_irq_q;
  assign irq_o = irq_q;

endmodule

// [verification/ucf_dma_model.sv]
/*
  Behavioural DMA engine that reports finished transfers to the flag block.
  Assumes the bench calls complete() from one process at a time.
*/
`timescale 1ns/100ps
module ucf_dma_model (
  input wire logic clk_i,
  output logic done_o,
  output logic dir_in_o,
  output logic [2:0] ep_o
);
  initial begin
    done_o = 1'b0;
    dir_in_o = 1'b0;
    ep_o = 3'h0;
  end
  // Qualifiers flip once the pulse is over so stale values cannot pass
  task automatic complete(input logic d, input logic [2:0] e);
    @(posedge clk_i);
    done_o <= 1'b1;
    dir_in_o <= d;
    ep_o <= e;
    @(posedge clk_i);
    done_o <= 1'b0;
    dir_in_o <= ~d;
    ep_o <= ~e;
  endtask
endmodule

// [verification/ucf_dma_flags_asserts.sv]
/*
  Port-level checks for the DMA completion flag block.
  Assumes it is bound to ucf_dma_flags and shares its clock and reset.
*/
`timescale 1ns/100ps
module ucf_dma_flags_asserts
  import ucf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic [DAT_W-1:0] wb_dat_o,
  input wire logic dma_done_i,
  input wire logic dma_dir_in_i,
  input wire logic [2:0] dma_ep_i,
  input wire logic [EP_W-1:0] out_go_o,
  input wire logic [EP_W-1:0] in_go_o,
  input wire logic [EP_W-1:0] out_reload_o,
  input wire logic [EP_W-1:0] in_reload_o,
  input wire logic dma_go_irq_o,
  input wire logic dma_rld_irq_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence s_done_ep;
    dma_done_i && dma_ep_i != 3'h0;
  endsequence
  a_bus_answer: assert property (s_take |=> s_pulse)
    else $error("ack not one pulse after request");
  a_go_clear: assert property (s_done_ep ##0 !dma_dir_in_i && !out_reload_o[dma_ep_i]
    |=> !out_go_o[$past(dma_ep_i)]) else $error("OUT go bit kept");
  a_rld_clear: assert property (s_done_ep ##0 dma_dir_in_i |=> !in_reload_o[$past(dma_ep_i)])
    else $error("IN reload bit kept");
  a_dir_apart: assert property (dma_done_i && !dma_dir_in_i && !wb_cyc_i
    |=> $stable(in_go_o) && $stable(in_reload_o)) else $error("OUT event moved IN bits");
  a_ep0_none: assert property (!out_go_o[0] && !in_go_o[0])
    else $error("endpoint 0 go bit set");
  a_irq_sum: assert property (dma_go_irq_o || dma_rld_irq_o |-> irq_o)
    else $error("irq_o low with DMA request");
  a_go_cause: assert property ($rose(dma_go_irq_o) |-> $past(dma_done_i, 2) || $past(wb_ack_o))
    else $error("done request without cause");
  a_rld_cause: assert property ($rose(dma_rld_irq_o) |-> $past(dma_done_i, 2) || $past(wb_ack_o))
    else $error("reload request without cause");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(wb_ack_o))
    else $error("irq_o fell without access");
  a_dat_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
    |=> $stable(wb_dat_o)) else $error("read data moved");
  a_rsv_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) < OFS_OUT_IE
    |-> wb_dat_o[15:8] == 8'h00 && !wb_dat_o[0]) else $error("reserved flag bits set");
endmodule
bind ucf_dma_flags ucf_dma_flags_asserts i_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o, .wb_dat_o,
  .dma_done_i, .dma_dir_in_i, .dma_ep_i, .out_go_o, .in_go_o, .out_reload_o,
  .in_reload_o, .dma_go_irq_o, .dma_rld_irq_o, .irq_o
);

// [verification/tb_ucf_dma_flags.sv]
/*
  Self-checking bench for the DMA completion flag block.
  Assumes the DMA model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
module tb_ucf_dma_flags
  import ucf_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [DAT_W-1:0] wb_dat_i = DAT_ZERO;
  logic [DAT_W-1:0] wb_dat_o;
  logic [DAT_W-1:0] rd;
  logic wb_ack_o;
  logic dma_done_i;
  logic dma_dir_in_i;
  logic [2:0] dma_ep_i;
  logic [EP_W-1:0] out_go_o;
  logic [EP_W-1:0] in_go_o;
  logic [EP_W-1:0] out_reload_o;
  logic [EP_W-1:0] in_reload_o;
  logic dma_go_irq_o;
  logic dma_rld_irq_o;
  logic irq_o;
  int n_mismatch = 0;
  int compares = 0;

  ucf_dma_flags i_dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .wb_dat_o, .dma_done_i, .dma_dir_in_i, .dma_ep_i, .out_go_o, .in_go_o,
    .out_reload_o, .in_reload_o, .dma_go_irq_o, .dma_rld_irq_o, .irq_o
  );
  ucf_dma_model i_dma (.clk_i, .done_o(dma_done_i), .dir_in_o(dma_dir_in_i), .ep_o(dma_ep_i));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic results();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [DAT_W-1:0] e, input logic [DAT_W-1:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  function automatic logic [DAT_W-1:0] irqs();
    return {29'h0000_0000, dma_go_irq_o, dma_rld_irq_o, irq_o};
  endfunction

  // The master never assumes a latency; a wait ends on ack or after the 20-cycle bound
  task automatic bus(input logic we, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED wb_ack_o exp 1 got %b", wb_ack_o);
      results();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rdc(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e, input string nm);
    bus(1'b0, a, DAT_ZERO);
    chk(nm, e, rd);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 12; i++) begin
      rdc(8'(i * 4), DAT_ZERO, "reset_reg");
    end
    chk("ctl_outs", DAT_ZERO, {out_go_o, in_go_o, out_reload_o, in_reload_o});
    chk("irqs", DAT_ZERO, irqs());
  endtask

  task automatic t_done();
    bus(1'b1, OFS_OUT_IE, 32'h0000_0040);
    bus(1'b1, OFS_OUT_CTRL, 32'h0000_0040);
    i_dma.complete(1'b0, 3'h6);
    @(negedge clk_i);
    chk("out_go_o", DAT_ZERO, {24'h00_0000, out_go_o});
    @(negedge clk_i);
    chk("irqs", 32'h0000_0005, irqs());
    rdc(OFS_OUT_DONE, 32'h0000_0040, "out_done");
    rdc(OFS_IN_DONE, DAT_ZERO, "in_done");
    rdc(OFS_OUT_RLD, DAT_ZERO, "out_rld");
    bus(1'b1, OFS_OUT_DONE, 32'h0000_00be);
    rdc(OFS_OUT_DONE, 32'h0000_0040, "out_done_w0");
    bus(1'b1, OFS_OUT_DONE, 32'h0000_0040);
    rdc(OFS_OUT_DONE, DAT_ZERO, "out_done_w1");
    chk("irqs", DAT_ZERO, irqs());
  endtask

  task automatic t_reload();
    bus(1'b1, OFS_IN_CTRL, 32'h0000_8080);
    i_dma.complete(1'b1, 3'h7);
    @(negedge clk_i);
    chk("in_ctl", 32'h0000_0080, {16'h0000, in_reload_o, in_go_o});
    @(negedge clk_i);
    chk("irqs", DAT_ZERO, irqs());
    rdc(OFS_IN_RLD, 32'h0000_0080, "in_rld");
    rdc(OFS_IN_DONE, DAT_ZERO, "in_done");
    rdc(OFS_SRC, DAT_ZERO, "src_masked");
    bus(1'b1, OFS_IN_IE, 32'h0000_0080);
    @(negedge clk_i);
    chk("irqs", 32'h0000_0003, irqs());
    rdc(OFS_SRC, 32'h0000_003f, "src");
    rdc(OFS_IN_RLD, DAT_ZERO, "in_rld_rd");
    chk("irqs", DAT_ZERO, irqs());
  endtask

  task automatic t_race();
    i_dma.complete(1'b0, 3'h1);
    // Clear and a fresh completion land on the same edge
    fork
      bus(1'b1, OFS_OUT_DONE, 32'h0000_0002);
      i_dma.complete(1'b0, 3'h1);
    join
    rdc(OFS_OUT_DONE, 32'h0000_0002, "out_done_race");
    i_dma.complete(1'b0, 3'h0);
    rdc(OFS_OUT_DONE, 32'h0000_0002, "out_done_ep0");
    rdc(OFS_ERR, 32'h0000_0003, "err");
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_done();
    t_reload();
    t_race();
    results();
  end
endmodule
